// *** core/tsr_reducer.sv ***
`timescale 1ns/1ps

module tsr_reducer
    import tsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rec_valid,
    input wire logic rec_second,
    input wire logic rec_stop,
    input wire logic [tsr_pkg::RAW_W-1:0] rec_evt_a,
    input wire logic [tsr_pkg::RAW_W-1:0] rec_evt_b,
    input wire logic [tsr_pkg::RAW_W-1:0] rec_time,
    input wire logic [tsr_pkg::INT_W-1:0] rec_interp,
    input wire logic fast_mode,
    input wire logic sum_sel,
    input wire logic expand_en,
    input wire logic signed [tsr_pkg::RES_W-1:0] path_offset,
    output logic stamp_valid_r,
    output logic stamp_stop_r,
    output logic signed [tsr_pkg::ACC_W-1:0] stamp_r,
    output logic result_valid_r,
    output logic signed [tsr_pkg::RES_W-1:0] count_a_r,
    output logic signed [tsr_pkg::RES_W-1:0] count_b_r,
    output logic signed [tsr_pkg::RES_W-1:0] count_ab_r,
    output logic signed [tsr_pkg::ACC_W-1:0] gate_time_r,
    output logic inhibit_r
);

    // ****************************************************
    // Attempt merge
    // ****************************************************
    logic [RAW_W-1:0] first_a_r;
    logic [RAW_W-1:0] first_b_r;
    logic chan_a_pick_flag;
    logic chan_b_pick_flag;
    logic [RAW_W-1:0] sel_a;
    logic [RAW_W-1:0] sel_b;
    logic take_first;
    logic take_second;
    logic blk_clr;

    assign take_first = rec_valid && !rec_second;
    assign take_second = rec_valid && rec_second;
    assign blk_clr = take_first && rec_interp[BLK_START_BIT];
    assign chan_a_pick_flag = rec_interp[PICK_A_BIT];
    assign chan_b_pick_flag = rec_interp[PICK_B_BIT];

    always_comb
    begin
        sel_a = chan_a_pick_flag ? rec_evt_a - 32'h0000_0001 : first_a_r;
        sel_b = chan_b_pick_flag ? rec_evt_b - 32'h0000_0001 : first_b_r;
    end

    // First record: counts and status only
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_a_r <= '0;
            first_b_r <= '0;
            inhibit_r <= 1'b0;
        end
        else if (take_first)
        begin
            first_a_r <= rec_evt_a;
            first_b_r <= rec_evt_b;
            inhibit_r <= rec_interp[INHIBIT_BIT];
        end
    end

    // ****************************************************
    // Rollover trackers
    // ****************************************************
    logic ev_a_ok;
    logic ev_b_ok;
    logic tm_ok;
    logic [ACC_W-1:0] ev_a;
    logic [ACC_W-1:0] ev_b;
    logic [ACC_W-1:0] tm;

    tsr_roll u_roll_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(blk_clr),
        .in_valid(take_second),
        .raw(sel_a),
        .fast(fast_mode),
        .out_valid(ev_a_ok),
        .corr(ev_a)
    );

    tsr_roll u_roll_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(blk_clr),
        .in_valid(take_second),
        .raw(sel_b),
        .fast(fast_mode),
        .out_valid(ev_b_ok),
        .corr(ev_b)
    );

    tsr_roll u_roll_t (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(blk_clr),
        .in_valid(take_second),
        .raw(rec_time),
        .fast(fast_mode),
        .out_valid(tm_ok),
        .corr(tm)
    );

    // ****************************************************
    // Stage one side data
    // ****************************************************
    logic [INTERP_VAL_W-1:0] s1_interp_r;
    logic s1_stop_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_interp_r <= '0;
            s1_stop_r <= 1'b0;
        end
        else if (take_second)
        begin
            s1_interp_r <= rec_interp[INTERP_VAL_W-1:0];
            s1_stop_r <= rec_stop;
        end
    end

    // ****************************************************
    // Stamps and results
    // ****************************************************
    logic signed [ACC_W-1:0] raw_stamp;
    logic signed [ACC_W-1:0] stamp;
    logic signed [ACC_W-1:0] diff_a;
    logic signed [ACC_W-1:0] diff_b;
    logic signed [ACC_W-1:0] start_a_r;
    logic signed [ACC_W-1:0] start_b_r;
    logic signed [ACC_W-1:0] start_ts_r;
    logic s1_valid;

    assign s1_valid = ev_a_ok && ev_b_ok && tm_ok;

    // 2 ns ticks less 0.1 ns steps
    always_comb
    begin
        raw_stamp = $signed(tm * TICK_IN_LSB) - $signed(ACC_W'(s1_interp_r));
        stamp = s1_stop_r ? raw_stamp + ACC_W'(path_offset) : raw_stamp;
        diff_a = $signed(ev_a) - start_a_r;
        diff_b = $signed(ev_b) - start_b_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_a_r <= '0;
            start_b_r <= '0;
            start_ts_r <= '0;
        end
        else if (s1_valid && !s1_stop_r)
        begin
            start_a_r <= $signed(ev_a);
            start_b_r <= $signed(ev_b);
            start_ts_r <= stamp;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stamp_valid_r <= 1'b0;
            stamp_stop_r <= 1'b0;
            stamp_r <= '0;
        end
        else
        begin
            stamp_valid_r <= s1_valid;
            if (s1_valid)
            begin
                stamp_stop_r <= s1_stop_r;
                stamp_r <= stamp;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_valid_r <= 1'b0;
            count_a_r <= '0;
            count_b_r <= '0;
            count_ab_r <= '0;
            gate_time_r <= '0;
        end
        else
        begin
            result_valid_r <= s1_valid && s1_stop_r;
            if (s1_valid && s1_stop_r)
            begin
                count_a_r <= tsr_sat(diff_a, fast_mode);
                count_b_r <= tsr_sat(diff_b, fast_mode);
                count_ab_r <= sum_sel ? tsr_sat(diff_a + diff_b, fast_mode) : '0;
                gate_time_r <= expand_en ? stamp - start_ts_r : '0;
            end
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    a_pick_a_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take_second && !chan_a_pick_flag) |-> (sel_a == first_a_r)) else $error("A pick wrong");

    a_pick_b_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take_second && chan_b_pick_flag) |-> (sel_b + 32'h0000_0001 == rec_evt_b)) else $error("B pick wrong");

    a_time_second_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take_first && !blk_clr) |=> !tm_ok) else $error("time taken from first record");

    a_stamp_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take_second && !blk_clr) |=> ##1 stamp_valid_r) else $error("stamp not issued");

    a_start_no_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s1_valid && !s1_stop_r) |=> (stamp_r == $past(raw_stamp))) else $error("start stamp offset");

    a_result_on_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        result_valid_r |-> (stamp_valid_r && stamp_stop_r)) else $error("result without stop");

    a_sum_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        result_valid_r |-> (fast_mode ? ($signed(count_ab_r) <= 32'sh0000_7FFF
        && $signed(count_ab_r) >= -32'sh0000_7FFF) : 1'b1)) else $error("sum limit");

    a_count_b_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (result_valid_r && fast_mode) |-> ($signed(count_b_r) <= 32'sh0000_7FFF
        && $signed(count_b_r) >= -32'sh0000_7FFF)) else $error("count b limit");

    a_gate_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (result_valid_r && $past(expand_en)) |-> (gate_time_r == stamp_r - start_ts_r))
        else $error("gate time wrong");

endmodule // tsr_reducer

// *** core/tsr_roll.sv ***
`timescale 1ns/1ps

module tsr_roll
    import tsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic in_valid,
    input wire logic [tsr_pkg::RAW_W-1:0] raw,
    input wire logic fast,
    output logic out_valid,
    output logic [tsr_pkg::ACC_W-1:0] corr
);

    logic [ACC_W-1:0] base_r;
    logic seen_r;
    logic [ACC_W-1:0] cand;
    logic [ACC_W-1:0] step;
    logic wrap;

    always_comb
    begin
        step = fast ? ROLL_FAST : ROLL_NORMAL;
        cand = base_r + ACC_W'(fast ? (raw & FAST_MASK) : raw);
        wrap = seen_r && (cand < corr);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_r <= '0;
            seen_r <= 1'b0;
            corr <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= in_valid && !clr;
            if (clr)
            begin
                base_r <= '0;
                seen_r <= 1'b0;
            end
            else if (in_valid)
            begin
                seen_r <= 1'b1;
                base_r <= wrap ? base_r + step : base_r;
                corr <= wrap ? cand + step : cand;
            end
        end
    end

    a_roll_latency: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (in_valid && !clr) |=> out_valid) else $error("tracker output late");

    a_roll_monotonic: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (in_valid && seen_r && !clr) |=> (corr >= $past(corr))) else $error("stamp decreased");

endmodule // tsr_roll

// *** inc/tsr_pkg.sv ***
package tsr_pkg;

    // ****************************************************
    // Field layout
    // ****************************************************
    localparam int RAW_W = 32;
    localparam int ACC_W = 64;
    localparam int RES_W = 32;
    localparam int INT_W = 16;
    localparam int INTERP_VAL_W = 11;
    localparam int PICK_A_BIT = 13;
    localparam int PICK_B_BIT = 14;
    localparam int BLK_START_BIT = 15;
    localparam int INHIBIT_BIT = 12;

    // ****************************************************
    // Rollover and limits
    // ****************************************************
    localparam logic [ACC_W-1:0] ROLL_NORMAL = 64'h0000_0001_0000_0000;
    localparam logic [ACC_W-1:0] ROLL_FAST = 64'h0000_0000_0001_0000;
    localparam logic [RAW_W-1:0] FAST_MASK = 32'h0000_FFFF;
    localparam logic signed [ACC_W-1:0] LIM_NORMAL = 64'sh0000_0000_7FFF_FFFF;
    localparam logic signed [ACC_W-1:0] LIM_FAST = 64'sh0000_0000_0000_7FFF;

    // ****************************************************
    // Time scale, stamps in tenths of a nanosecond
    // ****************************************************
    localparam int TICK_PS = 2000;
    localparam int INTERP_PS = 100;
    localparam logic [ACC_W-1:0] TICK_IN_LSB = ACC_W'(TICK_PS / INTERP_PS);

    function automatic logic signed [RES_W-1:0] tsr_sat(
        input logic signed [ACC_W-1:0] v,
        input logic fast
    );
        logic signed [ACC_W-1:0] lim;
        lim = fast ? LIM_FAST : LIM_NORMAL;
        if (v > lim)
        begin
            return lim[RES_W-1:0];
        end
        else if (v < -lim)
        begin
            return RES_W'(-lim);
        end
        return v[RES_W-1:0];
    endfunction

endpackage

// *** verification/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    import tsr_pkg::*;

    typedef struct {
        logic stop, inh, fa, fb;
        logic [31:0] e1a, e2a, e1b, e2b, tm;
        logic [10:0] iv;
        logic [63:0] stamp;
        logic [31:0] ca, cb, cab;
        logic [63:0] gate;
    } tsr_row_t;

    logic sys_clk = 1'b0;
    logic rst_n, fast_mode, sum_sel, expand_en;
    logic signed [RES_W-1:0] path_offset;
    logic rec_valid, rec_second, rec_stop;
    logic [RAW_W-1:0] rec_evt_a, rec_evt_b, rec_time;
    logic [INT_W-1:0] rec_interp;
    logic stamp_valid_r, stamp_stop_r, result_valid_r, inhibit_r;
    logic signed [ACC_W-1:0] stamp_r, gate_time_r;
    logic signed [RES_W-1:0] count_a_r, count_b_r, count_ab_r;
    int err_total = 0;
    int comparisons = 0;
    tsr_row_t rows [8];

    always #2 sys_clk = ~sys_clk;

    tsr_instr_model tsr_instr_model_i (.sys_clk(sys_clk), .rec_valid(rec_valid),
        .rec_second(rec_second), .rec_stop(rec_stop), .rec_evt_a(rec_evt_a),
        .rec_evt_b(rec_evt_b), .rec_time(rec_time), .rec_interp(rec_interp));

    tsr_reducer tsr_reducer_i (.sys_clk(sys_clk), .rst_n(rst_n), .rec_valid(rec_valid),
        .rec_second(rec_second), .rec_stop(rec_stop), .rec_evt_a(rec_evt_a),
        .rec_evt_b(rec_evt_b), .rec_time(rec_time), .rec_interp(rec_interp),
        .fast_mode(fast_mode), .sum_sel(sum_sel), .expand_en(expand_en),
        .path_offset(path_offset), .stamp_valid_r(stamp_valid_r),
        .stamp_stop_r(stamp_stop_r), .stamp_r(stamp_r), .result_valid_r(result_valid_r),
        .count_a_r(count_a_r), .count_b_r(count_b_r), .count_ab_r(count_ab_r),
        .gate_time_r(gate_time_r), .inhibit_r(inhibit_r));

    // ****************************************************
    // Compare and close
    // ****************************************************
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic run_row(input tsr_row_t r, input logic blk);
        int n;
        tsr_instr_model_i.send(r.stop, r.inh, blk, r.fa, r.fb, r.e1a, r.e2a, r.e1b, r.e2b, r.tm,
            r.iv);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (stamp_valid_r !== 1'b1 && n < 8);
        check("latency", 64'(n), 64'h1);
        check("stamp", stamp_r, r.stamp);
        check("stop flag", 64'(stamp_stop_r), 64'(r.stop));
        check("result valid", 64'(result_valid_r), 64'(r.stop));
        check("inhibit", 64'(inhibit_r), 64'(r.inh));
        if (r.stop)
        begin
            check("count a", count_a_r, r.ca);
            check("count b", count_b_r, r.cb);
            check("count ab", count_ab_r, r.cab);
            check("gate time", gate_time_r, r.gate);
        end
        @(posedge sys_clk);
        #1;
        check("stamp pulse", 64'(stamp_valid_r), 64'h0);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        rst_n = 1'b0;
        fast_mode = 1'b0;
        sum_sel = 1'b1;
        expand_en = 1'b1;
        path_offset = 32'h0000_0005;
        rows[0] = '{0, 0, 0, 1, 32'h0000_0064, 32'h0000_03E7, 32'h0000_0007, 32'h0000_00C9,
            32'h0000_000A, 11'h003, 64'h0000_0000_0000_00C5, 0, 0, 0, 0};
        rows[1] = '{1, 0, 1, 0, 32'h0000_0005, 32'h0000_0097, 32'h0000_0104, 32'h0000_0003,
            32'h0000_0014, 11'h000, 64'h0000_0000_0000_0195, 32'h0000_0032, 32'h0000_003C,
            32'h0000_006E, 64'h0000_0000_0000_00D0};
        rows[2] = '{0, 0, 0, 1, 32'hFFFF_FFF0, 32'h0000_0001, 32'h0000_0002, 32'h0000_010F,
            32'hFFFF_FFFE, 11'h007, 64'h0000_0013_FFFF_FFD1, 0, 0, 0, 0};
        rows[3] = '{1, 0, 1, 0, 32'h0000_0004, 32'h0000_0011, 32'h0000_012C, 32'h0000_0005,
            32'h0000_0003, 11'h00A, 64'h0000_0014_0000_0037, 32'h0000_0020, 32'h0000_001E,
            32'h0000_003E, 64'h0000_0000_0000_0066};
        rows[4] = '{0, 1, 1, 0, 32'h0000_0000, 32'h0001_0000, 32'h0001_0005, 32'h0000_0000,
            32'h0000_FFF0, 11'h000, 64'h0000_0000_0013_FEC0, 0, 0, 0, 0};
        rows[5] = '{1, 0, 0, 0, 32'h0000_0003, 32'h0000_0000, 32'h0002_9000, 32'h0000_0000,
            32'h0000_0002, 11'h000, 64'h0000_0000_0014_0024, 32'h0000_0004, 32'h0000_7FFF,
            0, 0};
        rows[6] = '{0, 0, 0, 0, 32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000,
            32'h0000_0001, 11'h000, 64'h0000_0000_0000_0014, 0, 0, 0, 0};
        rows[7] = '{1, 0, 0, 0, 32'h0000_0005, 32'h0000_0000, 32'h0000_0009, 32'h0000_0000,
            32'h0000_0003, 11'h000, 64'h0000_0000_0000_0038, 32'h0000_0004, 32'h0000_0007,
            0, 0};
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            run_row(rows[i], 1'b0);
        end
        // Mid-run reset, then fast mode with offset below zero
        @(posedge sys_clk);
        rst_n <= 1'b0;
        fast_mode <= 1'b1;
        sum_sel <= 1'b0;
        expand_en <= 1'b0;
        path_offset <= 32'hFFFF_FFFC;
        repeat (2) @(posedge sys_clk);
        #1;
        check("stamp in reset", stamp_r, 64'h0);
        check("count a in reset", count_a_r, 64'h0);
        check("gate in reset", gate_time_r, 64'h0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        run_row(rows[4], 1'b0);
        run_row(rows[5], 1'b0);
        // Block start restarts the trackers, no false rollover
        run_row(rows[6], 1'b1);
        run_row(rows[7], 1'b0);
        end_sim();
    end

    initial
    begin
        #100000;
        err_total++;
        end_sim();
    end
endmodule // tb_top

// *** verification/tsr_instr_model.sv ***
`timescale 1ns/1ps

module tsr_instr_model
    import tsr_pkg::*;
(
    input wire logic sys_clk,
    output logic rec_valid,
    output logic rec_second,
    output logic rec_stop,
    output logic [tsr_pkg::RAW_W-1:0] rec_evt_a,
    output logic [tsr_pkg::RAW_W-1:0] rec_evt_b,
    output logic [tsr_pkg::RAW_W-1:0] rec_time,
    output logic [tsr_pkg::INT_W-1:0] rec_interp
);
    initial
    begin
        rec_valid = 1'b0;
        rec_second = 1'b0;
        rec_stop = 1'b0;
        rec_evt_a = '0;
        rec_evt_b = '0;
        rec_time = '0;
        rec_interp = '0;
    end

    // ****************************************************
    // One sample: first record, then second record
    // ****************************************************
    task automatic send(input logic stop, inh, blk, fa, fb,
        input logic [RAW_W-1:0] e1a, e2a, e1b, e2b, tm, input logic [10:0] iv);
        @(posedge sys_clk);
        rec_valid <= 1'b1;
        rec_second <= 1'b0;
        rec_stop <= ~stop;
        rec_evt_a <= e1a;
        rec_evt_b <= e1b;
        rec_time <= ~tm;
        rec_interp <= {blk, 2'h0, inh, 12'h000};
        @(posedge sys_clk);
        rec_second <= 1'b1;
        rec_stop <= stop;
        rec_evt_a <= e2a;
        rec_evt_b <= e2b;
        rec_time <= tm;
        rec_interp <= {1'b0, fb, fa, 2'h0, iv};
        @(posedge sys_clk);
        rec_valid <= 1'b0;
        rec_evt_a <= ~e2a;
        rec_evt_b <= ~e2b;
        rec_time <= ~tm;
        rec_interp <= ~{1'b0, fb, fa, 2'h0, iv};
    endtask
endmodule // tsr_instr_model
